/* pic_capture.sv */
// Pulse interval capture unit: times the levels or period of one external
// signal in ticks of a divided measure clock and posts results to a register.
// Assumes a single core clock, an AXI4-Lite master and a DMA engine that
// reads results through the dma_* handshake.
//
// Contract
// - Soft reset clears all but clock gate
// - Capture on command enables capture
// - Off command wins, disables capture
// - Begin measure command starts new capture
// - Measure clock is core over 2^(sel+1)
// - Edge select picks measured interval kind
// - Overwrite policy: drop or keep overwriting
// - Single measure halts after one result
// - Clear register write-one clears flags (here done, lost and saturated only; sample ready is not cleared)
// - DMA completion sets transfer done flag
// - Unread result overwritten sets lost flag
// - Counter saturation sets saturated flag
// - New result sets ready; read clears
// - Active flag mirrors capture enable
// - Select zero divides core clock by two
// - Mask bit gates each flag's interrupt
// - Result: 15-bit count plus level bit (every-edge mode only here; other edge kinds give a 16-bit count)
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns

module pic_capture
    import pic_pkg::*;
#(
    parameter int ADDR_W = 8,   // Byte address bits; only the low 8 are decoded
    parameter int DIV_W  = 4    // Width of the divider select field
)(
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // AXI4-Lite write address
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    // AXI4-Lite write response
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    // AXI4-Lite read data
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    // Measured signal, asynchronous to sys_clk
    input  wire logic                sig_in,
    // Peripheral DMA side
    output logic                     dma_req,
    output logic [15:0]              dma_data,
    input  wire logic                dma_ack,
    input  wire logic                dma_done,
    // Interrupt
    output logic                     irq
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The divider counter is 16 bits: a 4-bit select is all it can serve
    generate
        if (DIV_W != 4)
        begin : g_div_chk
            $error("pic_capture: DIV_W must be 4");
        end
        if (ADDR_W < 8)
        begin : g_addr_chk
            $error("pic_capture: ADDR_W must be at least 8");
        end
    endgenerate

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Last divider count for a select value: 2^(sel+1) core cycles per tick
    function automatic logic [15:0] pic_div_last(input logic [3:0] sel);
        logic [16:0] span;
        span = 17'h1 << (5'(sel) + 5'h1);
        return 16'(span - 17'h1);
    endfunction : pic_div_last

    // Write of one to a bit of the low byte, honouring its byte strobe
    function automatic logic pic_bit(input logic [31:0] d, input logic [3:0] s,
                                     input int pos);
        return s[pos / 8] & d[pos];
    endfunction : pic_bit

    // Decode of a readable or writable offset
    function automatic logic pic_mapped(input logic [7:0] a, input logic wr);
        logic hit;
        hit = 1'b0;
        case (a)
            PIC_OFF_GATE_ON, PIC_OFF_GATE_OFF, PIC_OFF_COMMAND, PIC_OFF_SETUP,
            PIC_OFF_CLEAR, PIC_OFF_IRQ_SET, PIC_OFF_IRQ_CLR:
                hit = wr | (a == PIC_OFF_SETUP);
            PIC_OFF_GATE_ST, PIC_OFF_FLAGS, PIC_OFF_MASK, PIC_OFF_DATA:
                hit = !wr | (a == PIC_OFF_SETUP);
            default:
                hit = 1'b0;
        endcase
        return hit;
    endfunction : pic_mapped

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    pic_state_t st_r;
    pic_state_t st_nxt;

    // Combinational view of the request being taken this cycle
    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic        wr_go;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [7:0]  rd_addr;
    logic        tick;
    logic        edge_hit;
    logic        lvl_now;
    logic [15:0] cnt_max;
    logic [15:0] cnt_inc;
    logic        soft_rst;

    // Handshake outputs straight from the state; a single slot per direction
    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;

    // Result and interrupt outputs
    assign dma_req  = st_r.flags[PIC_FLG_READY];
    assign dma_data = st_r.data;
    assign irq      = |(st_r.flags & st_r.mask);

    // ------------------------------------------------------------
    // Request decode and measurement terms
    // ------------------------------------------------------------
    // Address and data come from the held copy or straight from the bus
    always_comb
    begin
        aw_take  = s_axi_awvalid && s_axi_awready;
        w_take   = s_axi_wvalid && s_axi_wready;
        ar_take  = s_axi_arvalid && s_axi_arready;
        wr_addr  = st_r.aw_got ? st_r.awaddr : s_axi_awaddr[7:0];
        wr_data  = st_r.w_got ? st_r.wdata : s_axi_wdata;
        wr_strb  = st_r.w_got ? st_r.wstrb : s_axi_wstrb;
        wr_go    = (st_r.aw_got || aw_take) && (st_r.w_got || w_take);
        rd_addr  = s_axi_araddr[7:0];
        soft_rst = wr_go && (wr_addr == PIC_OFF_COMMAND)
                   && pic_bit(wr_data, wr_strb, PIC_CMD_SOFT_RESET);
        // One tick per 2^(sel+1) core cycles, so select zero halves the clock
        tick     = (st_r.pre == pic_div_last(st_r.setup[PIC_SET_DIV_LSB +: 4]));
        lvl_now  = st_r.sync2;
        // Edge kinds: 00 every edge, 01 falling, 1x rising
        case (st_r.setup[PIC_SET_EDGE_LSB +: 2])
            PIC_EDGE_ANY:  edge_hit = (lvl_now != st_r.lvl);
            PIC_EDGE_FALL: edge_hit = st_r.lvl && !lvl_now;
            default:       edge_hit = !st_r.lvl && lvl_now;
        endcase
        // Every-edge results keep bit 15 for the level; others use it as count
        cnt_max  = (st_r.setup[PIC_SET_EDGE_LSB +: 2] != PIC_EDGE_ANY) ? PIC_MAX_WIDE : PIC_MAX_EVERY;
        cnt_inc  = (st_r.cnt == cnt_max) ? cnt_max : 16'(st_r.cnt + 16'h1);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;

        // Input synchroniser; only the second stage is looked at
        st_nxt.sync1 = sig_in;
        st_nxt.sync2 = st_r.sync1;

        // Measure clock divider
        st_nxt.pre = tick ? 16'h0 : 16'(st_r.pre + 16'h1);

        // Write channel bookkeeping
        if (aw_take)
        begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr[7:0];
        end
        if (w_take)
        begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end

        // DMA fetched the result
        if (dma_ack)
        begin
            st_nxt.flags[PIC_FLG_READY] = 1'b0;
        end

        // Register reads; reading the result releases the ready flag
        if (ar_take)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = 32'h0;
            st_nxt.rresp  = pic_mapped(rd_addr, 1'b0) ? PIC_RESP_OKAY : PIC_RESP_DECERR;
            case (rd_addr)
                PIC_OFF_GATE_ST: st_nxt.rdata[PIC_GATE_BIT] = st_r.clk_gate;
                PIC_OFF_SETUP:   st_nxt.rdata[7:0] = st_r.setup;
                PIC_OFF_FLAGS:
                begin
                    st_nxt.rdata[3:0]            = st_r.flags;
                    st_nxt.rdata[PIC_FLG_ACTIVE] = st_r.active;
                end
                PIC_OFF_MASK:    st_nxt.rdata[3:0] = st_r.mask;
                PIC_OFF_DATA:
                begin
                    st_nxt.rdata[15:0] = st_r.data;
                    st_nxt.flags[PIC_FLG_READY] = 1'b0;
                end
                default:         st_nxt.rdata = 32'h0;
            endcase
        end

        // Register writes, performed once address and data have both arrived, held or taken this cycle
        if (wr_go)
        begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = pic_mapped(wr_addr, 1'b1) ? PIC_RESP_OKAY : PIC_RESP_DECERR;
            case (wr_addr)
                PIC_OFF_GATE_ON:
                    if (pic_bit(wr_data, wr_strb, PIC_GATE_BIT))
                    begin
                        st_nxt.clk_gate = 1'b1;
                    end
                PIC_OFF_GATE_OFF:
                    if (pic_bit(wr_data, wr_strb, PIC_GATE_BIT))
                    begin
                        st_nxt.clk_gate = 1'b0;
                    end
                PIC_OFF_COMMAND:
                begin
                    if (pic_bit(wr_data, wr_strb, PIC_CMD_ON))
                    begin
                        st_nxt.active = 1'b1;
                    end
                    if (pic_bit(wr_data, wr_strb, PIC_CMD_OFF))
                    begin
                        st_nxt.active = 1'b0;
                    end
                    // A start only counts while capture stays enabled
                    if (pic_bit(wr_data, wr_strb, PIC_CMD_BEGIN) && st_nxt.active)
                    begin
                        st_nxt.cst = PIC_ARM;
                        st_nxt.cnt = 16'h0;
                    end
                end
                PIC_OFF_SETUP:
                    if (wr_strb[0])
                    begin
                        st_nxt.setup = wr_data[7:0];
                    end
                PIC_OFF_CLEAR:
                    for (int i = 0; i < 3; i++)
                    begin
                        if (pic_bit(wr_data, wr_strb, i))
                        begin
                            st_nxt.flags[i] = 1'b0;
                        end
                    end
                PIC_OFF_IRQ_SET:
                    for (int i = 0; i < 4; i++)
                    begin
                        if (pic_bit(wr_data, wr_strb, i))
                        begin
                            st_nxt.mask[i] = 1'b1;
                        end
                    end
                PIC_OFF_IRQ_CLR:
                    for (int i = 0; i < 4; i++)
                    begin
                        if (pic_bit(wr_data, wr_strb, i))
                        begin
                            st_nxt.mask[i] = 1'b0;
                        end
                    end
                default:
                    st_nxt.bresp = st_nxt.bresp;
            endcase
        end

        // DMA completion after the register writes, so it beats a clear but not a soft reset
        if (dma_done)
        begin
            st_nxt.flags[PIC_FLG_DONE] = 1'b1;
        end

        // Disabling stops any measurement in progress
        if (!st_nxt.active)
        begin
            st_nxt.cst = PIC_IDLE;
        end

        // Measurement on each measure clock tick
        if (tick)
        begin
            st_nxt.lvl = lvl_now;
            case (st_r.cst)
                PIC_ARM:
                    if (edge_hit && st_nxt.cst == PIC_ARM)
                    begin
                        st_nxt.cst = PIC_RUN;
                        st_nxt.cnt = 16'h0;
                    end
                PIC_RUN:
                    if (st_nxt.cst == PIC_RUN)
                    begin
                        if (cnt_inc == cnt_max)
                        begin
                            st_nxt.flags[PIC_FLG_SAT] = 1'b1;
                        end
                        if (edge_hit)
                        begin
                            st_nxt.cnt = 16'h0;
                            // Unread result would be overwritten: lost sample
                            if (st_nxt.flags[PIC_FLG_READY])
                            begin
                                st_nxt.flags[PIC_FLG_LOST] = 1'b1;
                            end
                            // Policy zero freezes the held result after an overrun
                            if (!st_nxt.flags[PIC_FLG_READY] || st_r.setup[PIC_SET_OVERWRITE])
                            begin
                                st_nxt.data = cnt_inc;
                                if (cnt_max == PIC_MAX_EVERY)
                                begin
                                    st_nxt.data[PIC_DATA_LEVEL] = st_r.lvl;
                                end
                                st_nxt.flags[PIC_FLG_READY] = 1'b1;
                            end
                            if (st_r.setup[PIC_SET_SINGLE])
                            begin
                                st_nxt.cst = PIC_IDLE;
                            end
                        end
                        else
                        begin
                            st_nxt.cnt = cnt_inc;
                        end
                    end
                default:
                    st_nxt.cnt = st_r.cnt;
            endcase
        end

        // Soft reset returns the unit to reset, clock gate and bus kept
        if (soft_rst)
        begin
            st_nxt.active = 1'b0;
            st_nxt.setup  = PIC_SETUP_RST;
            st_nxt.flags  = 4'h0;
            st_nxt.mask   = 4'h0;
            st_nxt.data   = 16'h0;
            st_nxt.cst    = PIC_IDLE;
            st_nxt.cnt    = 16'h0;
            st_nxt.pre    = 16'h0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= PIC_ST_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

endmodule : pic_capture

/* pic_pkg.sv */
// Package for the pulse interval capture unit: register map, field layout,
// reset values, state encoding and the complete state record of the unit.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz core clock.
package pic_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PIC_OFF_GATE_ON  = 8'h50;  // Clock gate enable, write-only
    localparam logic [7:0] PIC_OFF_GATE_OFF = 8'h54;  // Clock gate disable, write-only
    localparam logic [7:0] PIC_OFF_GATE_ST  = 8'h58;  // Clock gate status, read-only
    localparam logic [7:0] PIC_OFF_COMMAND  = 8'h60;  // capture_command, write-only
    localparam logic [7:0] PIC_OFF_SETUP    = 8'h64;  // capture_setup, read/write
    localparam logic [7:0] PIC_OFF_CLEAR    = 8'h6c;  // flag_clear, write-only
    localparam logic [7:0] PIC_OFF_FLAGS    = 8'h70;  // capture_flags, read-only
    localparam logic [7:0] PIC_OFF_IRQ_SET  = 8'h74;  // irq_set_enable, write-only
    localparam logic [7:0] PIC_OFF_IRQ_CLR  = 8'h78;  // Mask clear, write-only
    localparam logic [7:0] PIC_OFF_MASK     = 8'h7c;  // Mask readback
    localparam logic [7:0] PIC_OFF_DATA     = 8'h80;  // Result, read clears sample ready

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PIC_CMD_SOFT_RESET  = 0;  // soft_reset_cmd
    localparam int PIC_CMD_ON          = 1;  // capture_on_cmd
    localparam int PIC_CMD_OFF         = 2;  // capture_off_cmd
    localparam int PIC_CMD_BEGIN       = 3;  // begin_measure_cmd
    localparam int PIC_SET_DIV_LSB     = 0;  // Divider select 3:0
    localparam int PIC_SET_EDGE_LSB    = 4;  // edge_select 5:4
    localparam int PIC_SET_OVERWRITE   = 6;  // overwrite_policy
    localparam int PIC_SET_SINGLE      = 7;  // single_measure
    localparam int PIC_FLG_DONE        = 0;  // transfer_done_flag
    localparam int PIC_FLG_LOST        = 1;  // Lost sample
    localparam int PIC_FLG_SAT         = 2;  // Duration saturated
    localparam int PIC_FLG_READY       = 3;  // sample_ready_flag
    localparam int PIC_FLG_ACTIVE      = 8;  // capture_active_flag
    localparam int PIC_GATE_BIT        = 1;  // Clock gate bit
    localparam int PIC_DATA_LEVEL      = 15; // Level bit of a result

    // ------------------------------------------------------------
    // Encodings, widths and reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  PIC_EDGE_ANY     = 2'h0;  // Every edge
    localparam logic [1:0]  PIC_EDGE_FALL    = 2'h1;  // Falling to falling
    localparam logic [15:0] PIC_MAX_EVERY    = 16'h7fff; // 15-bit count
    localparam logic [15:0] PIC_MAX_WIDE     = 16'hffff; // Level bit used as count
    localparam logic [7:0]  PIC_SETUP_RST    = 8'h00;
    localparam logic [1:0]  PIC_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  PIC_RESP_DECERR  = 2'h3;

    // Measurement sequencer
    typedef enum logic [1:0] {
        PIC_IDLE,   // Halted, no measurement
        PIC_ARM,    // Waiting for the first qualifying edge
        PIC_RUN     // Counting between qualifying edges
    } pic_cap_t;

    // Whole state of the unit, registered as one record
    typedef struct packed {
        logic            clk_gate;
        logic            active;
        logic [7:0]      setup;
        logic [3:0]      flags;
        logic [3:0]      mask;
        logic [15:0]     data;
        pic_cap_t        cst;
        logic [15:0]     cnt;
        logic [15:0]     pre;
        logic            lvl;
        logic            sync1;
        logic            sync2;
        logic            aw_got;
        logic [7:0]      awaddr;
        logic            w_got;
        logic [31:0]     wdata;
        logic [3:0]      wstrb;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
    } pic_state_t;

    localparam pic_state_t PIC_ST_RST = '0;

endpackage : pic_pkg

/* pic_props.sv */
// Checker: bus answers, refusals and result clearing of pic_capture.
// Sees only the top ports; bound to every pic_capture below.
`timescale 1ns/1ns
module pic_props
    import pic_pkg::*;
#(parameter int ADDR_W = 8)(
    // Clock, reset and bus
    input wire logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr,
    input wire logic [1:0]        s_axi_bresp, s_axi_rresp,
    input wire logic [31:0]       s_axi_rdata,
    // Result side
    input wire logic dma_req, dma_ack
);
    // ------------------------------------------------------------
    // Bus steps and their answers
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence wr_t; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence rd_t; s_axi_arvalid && s_axi_arready; endsequence
    chk_write_answer: assert property (wr_t |=> s_axi_bvalid)
        else $error("write not answered");
    chk_read_answer: assert property (rd_t |=> s_axi_rvalid)
        else $error("read not answered");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    // A waiting answer blocks new writes, so no write is lost
    chk_bus_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer waits");
    chk_cmd_unread: assert property (rd_t ##0 s_axi_araddr == 8'h60 |=> s_axi_rresp == 2'h3)
        else $error("command register readable");
    chk_flags_ro: assert property (wr_t ##0 s_axi_awaddr == 8'h70 |=> s_axi_bresp == 2'h3)
        else $error("flags register writable");
    chk_ready_clear: assert property ($fell(dma_req) |->
        $past(dma_ack || s_axi_wvalid || s_axi_arvalid && s_axi_araddr == 8'h80))
        else $error("sample ready cleared without cause");
endmodule : pic_props

bind pic_capture pic_props #(.ADDR_W(ADDR_W)) u_props (.*);

/* pic_sig_model.sv */
// Partner model: the external signal whose intervals are timed.
// Assumes one clock; a square wave of half cycles per level while run.
`timescale 1ns/1ns
module pic_sig_model (
    // Clock, reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Wave control and output
    input  wire logic       run,
    input  wire logic [7:0] half,
    output logic            sig
);
    logic [7:0] cnt_r;
    // Level held while stopped; a shorter half takes effect at once
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            {cnt_r, sig} <= 9'h000;
        else if (run)
            {cnt_r, sig} <= (cnt_r >= half - 8'h01) ? {8'h00, ~sig} : {cnt_r + 8'h01, sig};
    end
endmodule : pic_sig_model

/* pulse_interval_capture_tb.sv */
// Bench for pic_capture: AXI4-Lite master, random and corner tests.
// Assumes the bound checker and pic_sig_model driving sig_in.
`timescale 1ns/1ns
module pulse_interval_capture_tb
    import pic_pkg::*;
;
    logic sys_clk = 0, rst_n = 0, sig_in, irq, dma_req, dma_ack = 0, dma_done = 0, run = 0;
    logic s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready, s_axi_bvalid, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_arready, s_axi_rvalid, s_axi_rready = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, half = 8'h4;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, k;
    logic [1:0]  s_axi_bresp, s_axi_rresp, m, s;
    logic [15:0] dma_data;
    int          errors = 0, comparisons = 0, cyc = 0, i;
    pic_capture DUT (.*);
    pic_sig_model MDL (.sys_clk(sys_clk), .rst_n(rst_n), .run(run), .half(half), .sig(sig_in));
    // ------------------------------------------------------------
    // Clock, hang guard and helpers
    // ------------------------------------------------------------
    initial forever #5 sys_clk = ~sys_clk;
    // The run needs well under this many cycles
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            errors++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Level bit counts too unless every edge is timed
    function automatic logic [31:0] mask_of(input logic [1:0] md);
        return (md != 2'h0) ? 32'hffff : 32'h7fff;
    endfunction : mask_of
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
        logic ao, wo;
        {ao, wo} = 2'b00;
        @(posedge sys_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_awaddr, s_axi_wdata} <= {2'b11, a, v};
        while (!(ao && wo))
        begin
            @(posedge sys_clk);
            ao = ao || s_axi_awready;
            wo = wo || s_axi_wready;
            {s_axi_awvalid, s_axi_wvalid} <= {!ao, !wo};
        end
        // bready comes late on purpose, so the answer must stand
        @(posedge sys_clk);
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk = '1,
                      input logic [1:0] er = 2'h0);
        @(posedge sys_clk);
        {s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge sys_clk);
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        chk(s_axi_rdata & mk, e);
    endtask : rd
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // Main sequence
    initial
    begin
        void'($urandom(32'h84da));
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        wr(8'h50, 32'h2);
        wr(8'h74, 32'hf);
        rd(8'h7c, 32'hf);
        wr(8'h64, 32'hff);
        wr(8'h60, 32'h1);
        rd(8'h58, 32'h2);
        rd(8'h7c, 32'h0);
        rd(8'h64, 32'h0);
        rd(8'h60, 32'h0, 32'h0, 2'h3);
        wr(8'h70, 32'h0, 2'h3);
        rd(8'h00, 32'h0, 32'h0, 2'h3);
        $display("test 1 done");
        wr(8'h60, 32'h2);
        wr(8'h60, 32'h0);
        rd(8'h70, 32'h100, 32'h100);
        wr(8'h60, 32'h6);
        rd(8'h70, 32'h0, 32'h100);
        $display("test 2 done");
        run <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            m = 2'(i);
            s = 2'($urandom_range(2, 0));
            k = 4'($urandom_range(10, 3));
            half <= 8'(k) << (s + (m == 2'h0));
            wr(8'h60, 32'h1);
            wr(8'h64, {24'h0, 2'b10, m, 2'b00, s});
            wr(8'h60, 32'h2);
            wr(8'h60, 32'h8);
            while (dma_req !== 1'b1) @(posedge sys_clk);
            chk({16'h0, dma_data} & mask_of(m), 32'(k));
            rd(8'h80, {28'h0, k}, mask_of(m));
            rd(8'h70, 32'h100, 32'h108);
            repeat (6 * half) @(posedge sys_clk);
            chk({31'h0, dma_req}, 32'h0);
        end
        $display("test 3 done");
        half <= 8'h4;
        wr(8'h60, 32'h1);
        wr(8'h64, 32'h20);
        wr(8'h60, 32'h2);
        wr(8'h60, 32'h8);
        while (dma_req !== 1'b1) @(posedge sys_clk);
        half <= 8'h6;
        #1 chk({31'h0, irq}, 32'h0);
        wr(8'h74, 32'h8);
        #1 chk({31'h0, irq}, 32'h1);
        repeat (60) @(posedge sys_clk);
        wr(8'h60, 32'h4);
        rd(8'h70, 32'ha, 32'h10a);
        wr(8'h6c, 32'h2);
        rd(8'h70, 32'h8, 32'h10a);
        @(posedge sys_clk) dma_ack <= 1'b1;
        @(posedge sys_clk) dma_ack <= 1'b0;
        #1 chk({30'h0, irq, dma_req}, 32'h0);
        rd(8'h80, 32'h4, 32'hffff);
        $display("test 4 done");
        @(posedge sys_clk) dma_done <= 1'b1;
        @(posedge sys_clk) dma_done <= 1'b0;
        rd(8'h70, 32'h1, 32'h1);
        #1 chk({31'h0, irq}, 32'h0);
        wr(8'h74, 32'h1);
        #1 chk({31'h0, irq}, 32'h1);
        wr(8'h6c, 32'h0);
        rd(8'h70, 32'h1, 32'h1);
        wr(8'h6c, 32'h1);
        #1 chk({31'h0, irq}, 32'h0);
        $display("test 5 done");
        test_done();
    end
endmodule : pulse_interval_capture_tb
